// >>> logic/gsld_pkg.sv
// Package: constants for the strap latch and decoder
package gsld_pkg;
  localparam int unsigned NUM_PINS        = 6;
  localparam int unsigned CODE_W          = 3;
  // Function codes carried per pin
  localparam logic [2:0]  CODE_UNUSED     = 3'h0;
  localparam logic [2:0]  CODE_EE_DISABLE = 3'h1;
  localparam logic [2:0]  CODE_ADDR_BIT2  = 3'h2;
  localparam logic [2:0]  CODE_SPI_WIRE   = 3'h3;
  // Timing: hold after reset release
  localparam int unsigned CLOCK_MHZ       = 100;
  localparam int unsigned HOLD_TIME_US    = 1000;
  localparam int unsigned HOLD_CYCLES     = HOLD_TIME_US * CLOCK_MHZ;
  localparam int unsigned HOLD_CNT_W      = 24;
  // Reset values of decoded outputs
  localparam logic        RST_EE_READ     = 1'b1;
  localparam logic        RST_ADDR_BIT2   = 1'b0;
  localparam logic        RST_SPI_3WIRE   = 1'b0;
endpackage

// >>> logic/gsld_dec_if.sv
// Interface: captured strap values and function codes toward the decoder
`timescale 1ns/1ps
`default_nettype none
interface gsld_dec_if #(
  parameter int unsigned NUM_PINS = gsld_pkg::NUM_PINS
);
  logic [NUM_PINS-1:0]   strap_value;
  logic [NUM_PINS*3-1:0] func_code;
  logic                  serial_interface_select_pin;
  logic                  ee_read_enable;
  logic                  slave_address_bit_two;
  logic                  spi_three_wire;
  modport ctrl (output strap_value, output func_code, output serial_interface_select_pin,
                input ee_read_enable, input slave_address_bit_two, input spi_three_wire);
  modport dec  (input strap_value, input func_code, input serial_interface_select_pin,
                output ee_read_enable, output slave_address_bit_two, output spi_three_wire);
endinterface
`default_nettype wire

// >>> logic/gsld_decode.sv
// Combinational decode of captured strap values by per-pin function code
`timescale 1ns/1ps
`default_nettype none
module gsld_decode #(
  parameter int unsigned NUM_PINS = gsld_pkg::NUM_PINS
) (
  gsld_dec_if.dec d
);
  // Field extraction used for every pin
  function automatic logic [2:0] code_of(input logic [NUM_PINS*3-1:0] codes, input int idx);
    code_of = codes[idx*3 +: 3];
  endfunction

  // Reduce all pins; codes 0 and 4..7 fall through and are ignored
  always_comb begin
    logic ee_off;
    logic a2;
    logic w3;
    ee_off = 1'b0;
    a2     = gsld_pkg::RST_ADDR_BIT2;
    w3     = gsld_pkg::RST_SPI_3WIRE;
    for (int i = 0; i < NUM_PINS; i++) begin
      case (code_of(d.func_code, i))
        // (RULE11) Any high disables
        gsld_pkg::CODE_EE_DISABLE: ee_off = ee_off | d.strap_value[i];
        // (RULE14) Highest index wins
        gsld_pkg::CODE_ADDR_BIT2:  a2 = d.strap_value[i];
        // (RULE17) Any high selects
        gsld_pkg::CODE_SPI_WIRE:   w3 = w3 | d.strap_value[i];
        // (RULE8) Value ignored
        default:                   ee_off = ee_off;
      endcase
    end
    // (RULE9) Skip read when disabled; (RULE10) read by default, I2C only
    d.ee_read_enable        = d.serial_interface_select_pin & ~ee_off;
    // (RULE12) Address bit in I2C; (RULE13) zero by default
    d.slave_address_bit_two = d.serial_interface_select_pin & a2;
    // (RULE15) Wire mode in SPI; (RULE16) four-wire default
    d.spi_three_wire        = ~d.serial_interface_select_pin & w3;
  end
endmodule
`default_nettype wire

// >>> logic/gsld_top.sv
// Strap latch: pin setup during reset, capture, hold, and decode at copy
// Function
// (RULE1) Latching off by factory default
// (RULE2) Non-volatile setting enables latching
// (RULE3) Disabled: configuration from stored settings only
// (RULE4) In reset: pins inputs, weak pull-down
// (RULE5) Capture at release, hold 1 ms
// (RULE6) Board keeps straps stable through hold
// (RULE7) Decode per-pin 3-bit code at copy
// (RULE8) Codes 0, 4-7 ignore value
// (RULE9) Code 1 high skips EEPROM read
// (RULE10) No code 1: attempt EEPROM read
// (RULE11) Several code 1: any high disables
// (RULE12) Code 2 gives address bit two
// (RULE13) No code 2: address bit zero
// (RULE14) Several code 2: highest pin wins
// (RULE15) Code 3 high selects three-wire SPI
// (RULE16) No code 3: four-wire SPI
// (RULE17) Several code 3: any high three-wire
// (RULE18) After hold pins return to normal
`timescale 1ns/1ps
`default_nettype none
module gsld_top #(
  parameter int unsigned NUM_PINS    = gsld_pkg::NUM_PINS,
  parameter int unsigned HOLD_CYCLES = gsld_pkg::HOLD_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic [NUM_PINS-1:0]   pin_in,
  input  wire logic [NUM_PINS-1:0]   func_out,
  input  wire logic [NUM_PINS-1:0]   func_oe,
  input  wire logic [NUM_PINS-1:0]   func_pull_down,
  input  wire logic                  latch_enable,
  input  wire logic [NUM_PINS*3-1:0] stored_func_code,
  input  wire logic                  stored_ee_read,
  input  wire logic                  stored_addr_bit2,
  input  wire logic                  stored_spi_3wire,
  input  wire logic                  serial_interface_select_pin,
  input  wire logic                  settings_copy,
  output logic [NUM_PINS-1:0]        pin_out,
  output logic [NUM_PINS-1:0]        pin_oe,
  output logic [NUM_PINS-1:0]        pin_pull_down,
  output logic [NUM_PINS-1:0]        pin_sample,
  output logic                       strap_hold,
  output logic                       ee_read_enable,
  output logic                       slave_address_bit_two,
  output logic                       spi_three_wire,
  output logic                       decode_done
);
  typedef enum {ST_RESET, ST_HOLD, ST_NORMAL} gsld_state_e;

  typedef struct packed {
    gsld_state_e                   state;
    logic [gsld_pkg::HOLD_CNT_W-1:0] cnt;
    logic [NUM_PINS-1:0]           sync1;
    logic [NUM_PINS-1:0]           sync2;
    logic [NUM_PINS-1:0]           sync3;
    logic [NUM_PINS-1:0]           pin_clean;
    logic [NUM_PINS-1:0]           captured;
    logic                          ee_read;
    logic                          addr_bit2;
    logic                          spi_3wire;
    logic                          done;
  } gsld_state_s;

  // Reset release through two flip-flops
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  gsld_state_s      r;
  gsld_state_s      next_r;
  gsld_dec_if #(.NUM_PINS(NUM_PINS)) dec_bus ();

  assign dec_bus.strap_value                 = r.captured;
  assign dec_bus.func_code                   = stored_func_code;
  assign dec_bus.serial_interface_select_pin = serial_interface_select_pin;

  gsld_decode #(.NUM_PINS(NUM_PINS)) u_decode (
    .d (dec_bus)
  );

  localparam logic [gsld_pkg::HOLD_CNT_W-1:0] HOLD_LAST =
    gsld_pkg::HOLD_CNT_W'(HOLD_CYCLES - 1);
  // Sync stages reset to zero; capturing before they fill would latch zeros
  localparam logic [gsld_pkg::HOLD_CNT_W-1:0] SYNC_LAST =
    gsld_pkg::HOLD_CNT_W'(3);

  // Next-state logic: sync, capture, hold timer, decode at copy
  always_comb begin
    next_r       = r;
    // Pins pass three flops; a change counts when stages two and three agree
    next_r.sync1 = pin_in;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (r.sync2[i] == r.sync3[i]) begin
        next_r.pin_clean[i] = r.sync3[i];
      end
    end
    case (r.state)
      ST_RESET: begin
        // (RULE5) Capture filtered levels
        if (r.cnt >= SYNC_LAST) begin
          next_r.captured = next_r.pin_clean;
          next_r.cnt      = '0;
          next_r.state    = ST_HOLD;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_HOLD: begin
        // (RULE5) Hold timer
        if (r.cnt >= HOLD_LAST) begin
          next_r.state = ST_NORMAL;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_NORMAL: begin
        next_r.cnt = r.cnt;
      end
      default: begin
        next_r.state = ST_RESET;
      end
    endcase
    // (RULE7) Decode only at settings copy
    if (settings_copy && r.state == ST_NORMAL) begin
      next_r.done = 1'b1;
      if (latch_enable) begin
        next_r.ee_read   = dec_bus.ee_read_enable;
        next_r.addr_bit2 = dec_bus.slave_address_bit_two;
        next_r.spi_3wire = dec_bus.spi_three_wire;
      end else begin
        // (RULE3) Stored settings only when latching off
        next_r.ee_read   = stored_ee_read;
        next_r.addr_bit2 = stored_addr_bit2;
        next_r.spi_3wire = stored_spi_3wire;
      end
    end
  end

  // State register; latching-off defaults until first copy
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      r           <= '0;
      r.state     <= ST_RESET;
      // (RULE1) Factory defaults before any copy
      r.ee_read   <= gsld_pkg::RST_EE_READ;
      r.addr_bit2 <= gsld_pkg::RST_ADDR_BIT2;
      r.spi_3wire <= gsld_pkg::RST_SPI_3WIRE;
    end else begin
      r <= next_r;
    end
  end

  // Pad control: strap setup in reset and hold, then normal functions
  always_comb begin
    if (r.state == ST_NORMAL) begin
      // (RULE18) Normal functions restored
      pin_out       = func_out;
      pin_oe        = func_oe;
      pin_pull_down = func_pull_down;
    end else begin
      // (RULE4) Inputs with pull-down
      pin_out       = '0;
      pin_oe        = '0;
      pin_pull_down = '1;
    end
  end

  // Outputs come from registers
  assign pin_sample            = r.captured;
  assign strap_hold            = (r.state != ST_NORMAL);
  assign ee_read_enable        = r.ee_read;
  assign slave_address_bit_two = r.addr_bit2;
  assign spi_three_wire        = r.spi_3wire;
  assign decode_done           = r.done;
endmodule
`default_nettype wire

// >>> dv/gsld_top_sva.sv
// Checker: pad setup, hold length and decode relations of the strap latch
`timescale 1ns/1ps
`default_nettype none
module gsld_top_sva #(
  parameter int unsigned NUM_PINS    = 6,
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic                  clock,
  input wire logic                  rst_b,
  input wire logic                  latch_enable,
  input wire logic [NUM_PINS*3-1:0] stored_func_code,
  input wire logic                  serial_interface_select_pin,
  input wire logic                  settings_copy,
  input wire logic [NUM_PINS-1:0]   pin_out,
  input wire logic [NUM_PINS-1:0]   pin_oe,
  input wire logic [NUM_PINS-1:0]   pin_pull_down,
  input wire logic [NUM_PINS-1:0]   pin_sample,
  input wire logic                  strap_hold,
  input wire logic                  ee_read_enable,
  input wire logic                  slave_address_bit_two,
  input wire logic                  spi_three_wire,
  input wire logic                  decode_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic        acc, x_ee, x_a2, x_3w;
  int unsigned hc;
  // Two release flops, three filter stages and the capture edge precede the hold
  localparam int unsigned HOLD_SLACK = 6;
  assign acc = settings_copy && !strap_hold && latch_enable;
  // Expected decode; later pins overwrite the address bit
  always_comb begin
    {x_ee, x_a2, x_3w} = 3'h4;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (stored_func_code[3*i+:3] == 3'h1 && pin_sample[i]) x_ee = 1'b0;
      if (stored_func_code[3*i+:3] == 3'h2) x_a2 = pin_sample[i];
      if (stored_func_code[3*i+:3] == 3'h3 && pin_sample[i]) x_3w = 1'b1;
    end
  end
  // Cycles spent held since reset release, bounds the hold window
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) hc <= 0;
    else if (strap_hold) hc <= hc + 1;
  end
  sequence s_copy;
    settings_copy && !strap_hold;
  endsequence
  AST_PAD_RESET: assert property (strap_hold |-> pin_out == '0 && pin_oe == '0
    && &pin_pull_down) else $error("pads not in strap setup");
  AST_HOLD_LEN: assert property ($fell(strap_hold) |-> hc >= HOLD_CYCLES
    && hc <= HOLD_CYCLES + HOLD_SLACK) else $error("hold length wrong");
  AST_HOLD_KEEP: assert property (strap_hold && hc < HOLD_CYCLES |=> strap_hold)
    else $error("hold ended early");
  AST_NO_DECODE: assert property (!(settings_copy && !strap_hold) |=>
    $stable({ee_read_enable, slave_address_bit_two, spi_three_wire})) else $error("decode moved");
  AST_DONE: assert property (s_copy |=> decode_done) else $error("done missing");
  AST_EE: assert property (acc && serial_interface_select_pin |=>
    ee_read_enable == $past(x_ee)) else $error("eeprom decode wrong");
  AST_A2: assert property (acc && serial_interface_select_pin |=>
    slave_address_bit_two == $past(x_a2)) else $error("address decode wrong");
  AST_3W: assert property (acc && !serial_interface_select_pin |=>
    spi_three_wire == $past(x_3w)) else $error("wire mode decode wrong");
endmodule
bind gsld_top gsld_top_sva #(.NUM_PINS(NUM_PINS), .HOLD_CYCLES(HOLD_CYCLES)) u_sva (.*);
`default_nettype wire

// >>> dv/gsld_strap_model.sv
// Board strap model: holds strap levels while the device latches them
`timescale 1ns/1ps
`default_nettype none
module gsld_strap_model (
  input  wire logic       clock,
  input  wire logic       strap_hold,
  input  wire logic [5:0] strap,
  output logic      [5:0] pin_in
);
  // straps held stable
  // After hold the pins toggle, so a late capture cannot pass by luck
  assign pin_in = strap_hold ? strap : (clock ? ~strap : strap);
endmodule
`default_nettype wire

// >>> dv/gsld_top_tb_top.sv
// Testbench: strap capture, hold timing and decode scenarios
`timescale 1ns/1ps
`default_nettype none
module gsld_top_tb_top;
  logic        clock, rst_b, le, sel, cp, s_ee, s_a2, s_3w, hold, ee, a2, w3, done;
  logic [5:0]  strap, pin_in, fo, foe, fpd, po, poe, ppd, ps;
  logic [17:0] code;
  logic [2:0]  e;
  int          fails, n_tests, cyc;
  integer      seed = 32'hDCE4E028;
  gsld_strap_model bd (.clock(clock), .strap_hold(hold), .strap(strap), .pin_in(pin_in));
  gsld_top #(.HOLD_CYCLES(20)) DUT (.clock(clock), .rst_b(rst_b), .pin_in(pin_in),
    .func_out(fo), .func_oe(foe), .func_pull_down(fpd), .latch_enable(le),
    .stored_func_code(code), .stored_ee_read(s_ee), .stored_addr_bit2(s_a2),
    .stored_spi_3wire(s_3w), .serial_interface_select_pin(sel), .settings_copy(cp),
    .pin_out(po), .pin_oe(poe), .pin_pull_down(ppd), .pin_sample(ps), .strap_hold(hold),
    .ee_read_enable(ee), .slave_address_bit_two(a2), .spi_three_wire(w3),
    .decode_done(done));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Live pad controls change every cycle; timeout far above eight wake-ups
  always @(posedge clock) begin
    cyc <= cyc + 1;
    {fo, foe, fpd} <= 18'($random(seed));
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Returns {ee, a2, w3}; codes other than 1..3 fall through untouched
  function automatic logic [2:0] dec(input logic [17:0] c, input logic [5:0] v);
    logic [2:0] r;
    r = 3'h4;
    for (int i = 0; i < 6; i++) begin
      if (c[3*i+:3] == 3'h1 && v[i]) r[2] = 1'b0;
      if (c[3*i+:3] == 3'h2) r[1] = v[i];
      if (c[3*i+:3] == 3'h3 && v[i]) r[0] = 1'b1;
    end
    return r;
  endfunction
  // Run 0 latching off, 1 all address code, 2 no codes, 3 codes 7, 6, 5, 4, 3, 1, rest random
  initial begin
    {rst_b, le, sel, cp, s_ee, s_a2, s_3w, strap, code} = '0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      rst_b <= 1'b0;
      {strap, sel, s_ee, s_a2, s_3w} <= 10'($random(seed));
      code <= k == 1 ? 18'h12492 : k == 2 ? 18'h0 : k == 3 ? 18'h3EB19 : 18'($random(seed));
      le <= (k != 0);
      repeat (6) @(posedge clock);
      @(negedge clock);
      chk(poe | ~ppd | po, 6'h0);
      @(posedge clock) rst_b <= 1'b1;
      repeat (5) @(posedge clock);
      cp <= 1'b1;
      @(posedge clock) cp <= 1'b0;
      for (int w = 0; w < 100 && hold === 1'b1; w++) @(posedge clock);
      @(negedge clock);
      chk({5'h0, done}, 6'h0);
      chk(ps, strap);
      chk(poe, foe);
      chk(po, fo);
      chk(ppd, fpd);
      @(posedge clock) cp <= 1'b1;
      @(posedge clock) cp <= 1'b0;
      repeat (2) @(negedge clock);
      // Serial mode gates each decoded function; latching off takes stored values
      e = le ? dec(code, strap) & {sel, sel, !sel} : {s_ee, s_a2, s_3w};
      chk({5'h0, ee}, {5'h0, e[2]});
      chk({5'h0, a2}, {5'h0, e[1]});
      chk({5'h0, w3}, {5'h0, e[0]});
      chk({5'h0, done}, 6'h1);
      $display("test %0d finished", k);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
